// ### inc/pbcr_pkg.sv
// Constants and carrier types for the basic control register bank
package pbcr_pkg;
   localparam int         REG_AW        = 5;
   localparam int         REG_DW        = 16;
   localparam int         NUM_REGS      = 32;
   localparam logic [4:0] ADDR_CTRL     = 5'h00;
   localparam logic [4:0] ADDR_MMD_CTRL = 5'h0D;
   localparam logic [4:0] ADDR_MMD_DATA = 5'h0E;
   localparam logic [4:0] ADDR_VENDOR   = 5'h10;
   localparam int         B_RESET       = 15;
   localparam int         B_LOOP        = 14;
   localparam int         B_SPD_LSB     = 13;
   localparam int         B_AN_EN       = 12;
   localparam int         B_PDOWN       = 11;
   localparam int         B_ISOLATE     = 10;
   localparam int         B_AN_RESTART  = 9;
   localparam int         B_DUPLEX      = 8;
   localparam int         B_COL_TEST    = 7;
   localparam int         B_SPD_MSB     = 6;
   localparam logic [15:0] CTRL_RESET   = 16'h1100;
   localparam logic [15:0] CTRL_WMASK   = 16'hFFC0;
   localparam logic [3:0]  MODE_GIG_STRAP = 4'hF;
   localparam int         MMD_DEVS      = 32;
   localparam int         MMD_REGS      = 64;
   localparam int         SOFT_RST_CYCLES = 4;

   typedef enum logic [1:0] {
      SPD_10   = 2'b00,
      SPD_100  = 2'b01,
      SPD_1000 = 2'b10,
      SPD_RSVD = 2'b11
   } pbcr_speed_t;

   typedef enum logic [1:0] {
      MMD_FN_ADDR  = 2'b00,
      MMD_FN_DATA  = 2'b01,
      MMD_FN_INC_RW = 2'b10,
      MMD_FN_INC_W = 2'b11
   } pbcr_mmd_fn_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } pbcr_req_t;

   typedef struct packed {
      logic        loopback;
      logic        power_down;
      logic        isolate;
      logic        col_test;
      logic        an_enable;
      logic        an_restart;
      logic        soft_reset;
      pbcr_speed_t speed;
      logic        full_duplex;
   } pbcr_ctrl_t;
endpackage

// ### rtl/pbcr_regs.sv
// Management register bank with the basic control register and indirect access
`timescale 1ns/10ps
module pbcr_regs (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire pbcr_pkg::pbcr_req_t req,
   input  wire logic [3:0]         mode_strap,
   input  wire logic               an_done,
   input  wire pbcr_pkg::pbcr_speed_t an_speed,
   input  wire logic               an_duplex,
   input  wire logic [15:0]        vendor_rdata,
   output logic [15:0]             rdata,
   output logic                    rvalid,
   output pbcr_pkg::pbcr_ctrl_t    ctrl
);
   import pbcr_pkg::*;

   logic        rst_s1_q, rst_s2_q;
   logic [1:0]  strap_cnt_q;
   logic [3:0]  strap_s1_q, strap_s2_q;
   logic [15:0] ctrl_q;
   logic [15:0] std_q [1:NUM_REGS-1];
   logic [15:0] mmd_ctrl_q, mmd_addr_q;
   logic [15:0] mmd_q [0:MMD_REGS-1];
   logic [2:0]  srst_cnt_q;
   logic        restart_q;
   logic        strap_done_q;
   logic        strap_gig_q;
   logic        wr_ctrl, wr_mmd_ctrl, wr_mmd_data;
   logic [5:0]  mmd_idx;
   logic        soft_rst;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Straps come from pins, synchronised before use
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         strap_s1_q <= 4'h0;
         strap_s2_q <= 4'h0;
      end else begin
         strap_s1_q <= mode_strap;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Strap latched a few edges after release, once synchroniser settled
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         strap_cnt_q  <= 2'h0;
         strap_done_q <= 1'b0;
         strap_gig_q  <= 1'b0;
      end else if (!strap_done_q) begin
         strap_cnt_q  <= strap_cnt_q + 2'h1;
         strap_done_q <= (strap_cnt_q == 2'h2);
         // Held so a software reset restores the power-up value, not the live pins
         if (strap_cnt_q == 2'h2) begin
            strap_gig_q <= (strap_s2_q == MODE_GIG_STRAP);
         end
      end
   end

   assign soft_rst    = (srst_cnt_q != 3'h0);
   assign wr_ctrl     = req.wr && req.addr == ADDR_CTRL;
   assign wr_mmd_ctrl = req.wr && req.addr == ADDR_MMD_CTRL;
   assign wr_mmd_data = req.wr && req.addr == ADDR_MMD_DATA;
   assign mmd_idx     = mmd_addr_q[5:0];

   // Basic control register
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         ctrl_q <= CTRL_RESET;
      end else if (strap_done_q == 1'b0 && strap_cnt_q == 2'h2) begin
         ctrl_q[B_SPD_MSB] <= (strap_s2_q == MODE_GIG_STRAP);
      end else if (soft_rst) begin
         // Software reset returns defaults but keeps strapped speed
         ctrl_q <= CTRL_RESET | ({15'h0, strap_gig_q} << B_SPD_MSB);
      end else if (wr_ctrl) begin
         ctrl_q          <= req.wdata & CTRL_WMASK;
         // Request bit is never stored; the counter below carries it
         ctrl_q[B_RESET] <= 1'b0;
      end else begin
         ctrl_q[B_AN_RESTART] <= 1'b0;
      end
   end

   // Software reset held for a short fixed pulse
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         srst_cnt_q <= 3'h0;
      end else if (wr_ctrl && !soft_rst && req.wdata[B_RESET]) begin
         srst_cnt_q <= 3'(SOFT_RST_CYCLES);
      end else if (soft_rst) begin
         srst_cnt_q <= srst_cnt_q - 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= wr_ctrl && !soft_rst && req.wdata[B_AN_RESTART];
      end
   end

   // Other direct registers plain storage; Dh/Eh handled below, 10h and up read back vendor_rdata
   generate
      for (genvar i = 1; i < NUM_REGS; i++) begin : g_std
         always_ff @(posedge clk or negedge rst_s2_q) begin
            if (!rst_s2_q) begin
               std_q[i] <= 16'h0000;
            end else if (req.wr && req.addr == 5'(i)) begin
               std_q[i] <= req.wdata;
            end
         end
      end
   endgenerate

   // Indirect access: Dh selects device/function, Eh carries address or data
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         mmd_ctrl_q <= 16'h0000;
         mmd_addr_q <= 16'h0000;
      end else if (wr_mmd_ctrl) begin
         mmd_ctrl_q <= req.wdata;
      end else if (mmd_ctrl_q[15:14] == MMD_FN_ADDR && wr_mmd_data) begin
         mmd_addr_q <= req.wdata;
      end else if (mmd_ctrl_q[15:14] != MMD_FN_ADDR && mmd_ctrl_q[15:14] != MMD_FN_DATA
                   && (wr_mmd_data || (req.rd && req.addr == ADDR_MMD_DATA)
                       && mmd_ctrl_q[15:14] == MMD_FN_INC_RW)) begin
         mmd_addr_q <= mmd_addr_q + 16'h0001;
      end
   end

   // Single store for all device addresses keeps area small
   always_ff @(posedge clk) begin
      if (wr_mmd_data && mmd_ctrl_q[15:14] != MMD_FN_ADDR) begin
         mmd_q[mmd_idx] <= req.wdata;
      end
   end

   // Read path, one cycle latency
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         rdata  <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (!req.rd) begin
            rdata <= 16'h0000;
         end else if (req.addr == ADDR_CTRL) begin
            rdata <= ctrl_q & CTRL_WMASK;
         end else if (req.addr == ADDR_MMD_CTRL) begin
            rdata <= mmd_ctrl_q;
         end else if (req.addr == ADDR_MMD_DATA) begin
            rdata <= (mmd_ctrl_q[15:14] == MMD_FN_ADDR) ? mmd_addr_q : mmd_q[mmd_idx];
         end else if (req.addr >= ADDR_VENDOR) begin
            rdata <= vendor_rdata;
         end else begin
            rdata <= std_q[req.addr];
         end
      end
   end

   // Effective control outputs
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         ctrl <= '0;
      end else begin
         ctrl.loopback   <= ctrl_q[B_LOOP];
         ctrl.power_down <= ctrl_q[B_PDOWN];
         ctrl.isolate    <= ctrl_q[B_ISOLATE];
         ctrl.col_test   <= ctrl_q[B_COL_TEST];
         ctrl.an_enable  <= ctrl_q[B_AN_EN];
         ctrl.an_restart <= restart_q;
         ctrl.soft_reset <= soft_rst;
         if (ctrl_q[B_AN_EN]) begin
            // Until negotiation finishes the forced bits still do not apply
            ctrl.speed       <= an_done ? an_speed : SPD_10;
            ctrl.full_duplex <= an_done ? an_duplex : 1'b0;
         end else begin
            ctrl.speed       <= pbcr_speed_t'({ctrl_q[B_SPD_MSB], ctrl_q[B_SPD_LSB]});
            ctrl.full_duplex <= ctrl_q[B_DUPLEX];
         end
      end
   end
endmodule

// ### testbench/pbcr_checker.sv
// Port assertions for the basic control register bank
`timescale 1ns/10ps
module pbcr_checker (
   input wire logic                  clk,
   input wire logic                  rstn,
   input wire pbcr_pkg::pbcr_req_t   req,
   input wire logic [3:0]            mode_strap,
   input wire logic                  an_done,
   input wire pbcr_pkg::pbcr_speed_t an_speed,
   input wire logic                  an_duplex,
   input wire logic [15:0]           vendor_rdata,
   input wire logic [15:0]           rdata,
   input wire logic                  rvalid,
   input wire pbcr_pkg::pbcr_ctrl_t  ctrl
);
   import pbcr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [15:0] wd1_q;
   logic [15:0] wd2_q;
   logic        srst_pend_q;
   // Writes landing during a soft reset are dropped; the port flag lags the
   // internal counter by one cycle, so the cycle after the request is masked too
   wire w0 = req.wr && req.addr == ADDR_CTRL && !ctrl.soft_reset && !srst_pend_q;
   always_ff @(posedge clk) begin
      wd1_q       <= req.wdata;
      wd2_q       <= wd1_q;
      srst_pend_q <= w0 && req.wdata[B_RESET];
   end
   sequence s_rst_pulse; ctrl.soft_reset [*4] ##1 !ctrl.soft_reset; endsequence
   sequence s_restart; ctrl.an_restart ##1 !ctrl.an_restart; endsequence
   chk_read_answer: assert property (rvalid == $past(req.rd)) else $error("rvalid timing");
   chk_idle_rdata: assert property (!rvalid |-> rdata == 16'h0000) else $error("rdata not idle");
   chk_ctrl_fixed: assert property (rvalid && $past(req.addr) == ADDR_CTRL |->
      rdata[5:0] == 6'h00 && !rdata[15]) else $error("fixed bits set");
   chk_vendor_read: assert property (req.rd && req.addr >= ADDR_VENDOR |=>
      rdata == $past(vendor_rdata)) else $error("vendor read");
   chk_soft_reset: assert property (w0 && req.wdata[B_RESET] |-> ##2 s_rst_pulse) else $error("soft reset");
   chk_an_restart: assert property (w0 && req.wdata[B_AN_RESTART] && !req.wdata[B_RESET] |->
      ##2 s_restart) else $error("restart pulse");
   chk_mode_bits: assert property (w0 && !req.wdata[B_RESET] |-> ##2
      ctrl.loopback == wd2_q[B_LOOP] && ctrl.isolate == wd2_q[B_ISOLATE] && ctrl.col_test == wd2_q[B_COL_TEST] &&
      ctrl.an_enable == wd2_q[B_AN_EN] && ctrl.power_down == wd2_q[B_PDOWN]) else $error("mode bits");
   chk_forced_speed: assert property (w0 && !req.wdata[B_RESET] && !req.wdata[B_AN_EN] |-> ##2
      ctrl.speed == {wd2_q[B_SPD_MSB], wd2_q[B_SPD_LSB]} && ctrl.full_duplex == wd2_q[B_DUPLEX])
      else $error("forced speed");
   chk_an_result: assert property (ctrl.an_enable && an_done && $stable(an_speed) && $stable(an_done) &&
      $stable(an_duplex) |-> ##[0:2] ctrl.speed == an_speed && ctrl.full_duplex == an_duplex)
      else $error("negotiated result");
endmodule
bind pbcr_regs pbcr_checker pbcr_checker_i (.clk(clk), .rstn(rstn), .req(req), .mode_strap(mode_strap),
   .an_done(an_done), .an_speed(an_speed), .an_duplex(an_duplex), .vendor_rdata(vendor_rdata),
   .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl));

// ### testbench/pbcr_host.sv
// Management host model issuing register accesses
`timescale 1ns/10ps
module pbcr_host (
   input wire logic              clk,
   output pbcr_pkg::pbcr_req_t   req,
   input wire logic [15:0]       rdata
);
   import pbcr_pkg::*;
   initial req = '0;
   // One-cycle strobe; answer taken the cycle after
   task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
      @(negedge clk);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      q = rdata;
      req = '0;
   endtask
endmodule

// ### testbench/test_phy_basic_control_register.sv
// Self-checking bench for the basic control register bank
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module test_phy_basic_control_register;
   import pbcr_pkg::*;
   logic        clk, rstn, an_done, an_duplex, rvalid;
   logic [3:0]  mode_strap;
   logic [4:0]  a;
   logic [15:0] vendor_rdata, rdata, q, w;
   logic [15:0] mirror [32];
   pbcr_speed_t an_speed;
   pbcr_req_t   req;
   pbcr_ctrl_t  ctrl;
   int          n_fail = 0, cmp_count = 0;
   pbcr_regs pbcr_regs_i (.clk(clk), .rstn(rstn), .req(req), .mode_strap(mode_strap), .an_done(an_done),
      .an_speed(an_speed), .an_duplex(an_duplex), .vendor_rdata(vendor_rdata), .rdata(rdata), .rvalid(rvalid),
      .ctrl(ctrl));
   pbcr_host pbcr_host_i (.clk(clk), .req(req), .rdata(rdata));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // Bits 15 and 9 self-clear, 5:0 are fixed
   function automatic logic [15:0] stored(logic [4:0] ad, logic [15:0] d);
      return (ad == ADDR_CTRL) ? d & 16'h7DC0 : d;
   endfunction
   function automatic logic [15:0] ctrl_def(logic [3:0] s);
      return 16'h1100 | ((s == 4'hF) ? 16'h0040 : 16'h0000);
   endfunction
   function automatic logic [4:0] mode_of(pbcr_ctrl_t c);
      return {c.loopback, c.power_down, c.isolate, c.col_test, c.an_enable};
   endfunction
   function automatic logic [4:0] exp_mode(logic [15:0] d);
      return {d[B_LOOP], d[B_PDOWN], d[B_ISOLATE], d[B_COL_TEST], d[B_AN_EN]};
   endfunction
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic do_reset(input logic [3:0] s);
      mode_strap = s;
      rstn = 0;
      repeat (6) @(negedge clk);
      rstn = 1;
      repeat (8) @(negedge clk);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end
   // Negotiation result moves slowly so the output can follow it
   initial begin
      forever begin
         repeat (8) @(negedge clk);
         an_done = 1'($urandom);
         an_speed = pbcr_speed_t'($urandom_range(2, 0));
         an_duplex = 1'($urandom);
      end
   end
   initial begin
      an_done = 0;
      an_speed = SPD_10;
      an_duplex = 0;
      vendor_rdata = 16'h0000;
      void'($urandom(32'h2fa956c6));
      do_reset(4'hF);
      pbcr_host_i.access(0, ADDR_CTRL, 16'h0000, q);
      `CHK(q, ctrl_def(4'hF))
      for (int i = 0; i < 40; i++) begin
         a = 5'($urandom_range(15, 0));
         if (a == ADDR_MMD_CTRL || a == ADDR_MMD_DATA) a = ADDR_CTRL;
         w = 16'($urandom) & ((a == ADDR_CTRL) ? 16'h7DFF : 16'hFFFF);
         pbcr_host_i.access(1, a, w, q);
         mirror[a] = stored(a, w);
         pbcr_host_i.access(0, a, 16'h0000, q);
         `CHK(q, mirror[a])
         if (a == ADDR_CTRL) begin
            `CHK(mode_of(ctrl), exp_mode(w))
            if (!w[B_AN_EN]) `CHK({ctrl.speed, ctrl.full_duplex}, {w[B_SPD_MSB], w[B_SPD_LSB], w[B_DUPLEX]})
         end
      end
      for (int i = 0; i < 8; i++) begin
         a = 5'(16 + $urandom_range(15, 0));
         vendor_rdata = 16'($urandom);
         pbcr_host_i.access(1, a, ~vendor_rdata, q);
         pbcr_host_i.access(0, a, 16'h0000, q);
         `CHK(q, vendor_rdata)
      end
      w = 16'($urandom);
      pbcr_host_i.access(1, ADDR_MMD_CTRL, 16'h0002, q);
      pbcr_host_i.access(1, ADDR_MMD_DATA, 16'h0010, q);
      pbcr_host_i.access(1, ADDR_MMD_CTRL, 16'h4002, q);
      pbcr_host_i.access(1, ADDR_MMD_DATA, w, q);
      pbcr_host_i.access(0, ADDR_MMD_DATA, 16'h0000, q);
      `CHK(q, w)
      pbcr_host_i.access(1, ADDR_MMD_CTRL, 16'hC002, q);
      pbcr_host_i.access(1, ADDR_MMD_DATA, ~w, q);
      pbcr_host_i.access(1, ADDR_MMD_DATA, w ^ 16'h00FF, q);
      pbcr_host_i.access(1, ADDR_MMD_CTRL, 16'h0002, q);
      pbcr_host_i.access(0, ADDR_MMD_DATA, 16'h0000, q);
      `CHK(q, 16'h0012)
      pbcr_host_i.access(1, ADDR_MMD_DATA, 16'h0010, q);
      pbcr_host_i.access(1, ADDR_MMD_CTRL, 16'h8002, q);
      pbcr_host_i.access(0, ADDR_MMD_DATA, 16'h0000, q);
      `CHK(q, ~w)
      pbcr_host_i.access(0, ADDR_MMD_DATA, 16'h0000, q);
      `CHK(q, w ^ 16'h00FF)
      pbcr_host_i.access(1, ADDR_CTRL, 16'h1340, q);
      repeat (2) @(negedge clk);
      pbcr_host_i.access(0, ADDR_CTRL, 16'h0000, q);
      `CHK(q, 16'h1140)
      pbcr_host_i.access(1, ADDR_CTRL, 16'h8000 | 16'h4480, q);
      repeat (10) @(negedge clk);
      pbcr_host_i.access(0, ADDR_CTRL, 16'h0000, q);
      `CHK(q, ctrl_def(4'hF))
      `CHK(mode_of(ctrl), 5'b00001)
      do_reset(4'h0);
      pbcr_host_i.access(0, ADDR_CTRL, 16'h0000, q);
      `CHK(q, ctrl_def(4'h0))
      final_report();
   end
endmodule
